// ### logic/tmrv_pkg.sv
// Shared constants for the lane voter
package tmrv_pkg;
    localparam int TMRV_MEM_W = 32;
    localparam int TMRV_LINK_W = 4;
    localparam int TMRV_LANES = 3;
    localparam logic [2:0] TMRV_MISMATCH_RST = 3'h0;
    localparam logic TMRV_FLAG_RST = 1'h0;
    typedef enum logic [1:0] {
        TMRV_ACTIVE = 2'b00,
        TMRV_STANDBY = 2'b01,
        TMRV_CHANGE = 2'b10
    } tmrv_role_e;
endpackage

// ### logic/tmrv_vote.sv
// Bitwise two-of-three voter with per-lane disagreement
`timescale 1ns/1ns
module tmrv_vote
    import tmrv_pkg::*;
#(
    parameter int W = 32
) (
    // Lane inputs
    input wire logic [W-1:0] laneA,
    input wire logic [W-1:0] laneB,
    input wire logic [W-1:0] laneC,
    // Voted result
    output logic [W-1:0] voted,
    output logic [2:0] laneOdd
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign voted[i] = (laneA[i] & laneB[i]) | (laneA[i] & laneC[i])
                | (laneB[i] & laneC[i]);
        end
    endgenerate
    // A lane is odd when it differs from the majority anywhere
    assign laneOdd[0] = |(laneA ^ voted);
    assign laneOdd[1] = |(laneB ^ voted);
    assign laneOdd[2] = |(laneC ^ voted);
endmodule

// ### logic/tmrv_voter_top.sv
// Lane voter: memory, link, watchdog, interlock and changeover
`timescale 1ns/1ns
module tmrv_voter_top
    import tmrv_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Memory read lanes
    input wire logic [TMRV_MEM_W-1:0] memRdA,
    input wire logic [TMRV_MEM_W-1:0] memRdB,
    input wire logic [TMRV_MEM_W-1:0] memRdC,
    input wire logic memRdValid,
    // Link receive lanes with lane-side fault flags
    input wire logic [TMRV_LINK_W-1:0] linkRxA,
    input wire logic [TMRV_LINK_W-1:0] linkRxB,
    input wire logic [TMRV_LINK_W-1:0] linkRxC,
    input wire logic linkRxValid,
    input wire logic linkRxErr,
    input wire logic ioModFault,
    // Lane watchdogs (pins)
    input wire logic wdogA,
    input wire logic wdogB,
    input wire logic wdogC,
    // Latch switches and pair control (pins)
    input wire logic latchTop,
    input wire logic latchBot,
    input wire logic ejectorOpen,
    input wire logic isActive,
    input wire logic peerTrigger,
    // Voted outputs
    output logic [TMRV_MEM_W-1:0] memVoted,
    output logic memVotedValid,
    output logic [TMRV_LINK_W-1:0] linkVoted,
    output logic linkVotedValid,
    output logic linkFault,
    output logic fpWatchdog,
    // Status and events
    output logic errorInd,
    output logic [2:0] laneMismatch,
    output logic [2:0] laneIrq,
    output logic changeoverReq,
    output logic goActive
);
    ////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [TMRV_MEM_W-1:0] mem;
        logic memV;
        logic [TMRV_LINK_W-1:0] link;
        logic linkV;
        logic linkF;
        logic [2:0] mis;
        logic err;
        logic [2:0] wdS1;
        logic [2:0] wdS2;
        logic [2:0] wdS3;
        logic [2:0] pinS1;
        logic [2:0] pinS2;
        logic [2:0] pinS3;
        logic latchSeen;
        logic [2:0] irq;
        logic fpWd;
        tmrv_role_e role;
        logic chg;
    } tmrv_state_s;

    tmrv_state_s st_reg;
    tmrv_state_s st_next;
    logic [TMRV_MEM_W-1:0] memMaj;
    logic [2:0] memOdd;
    logic [TMRV_LINK_W-1:0] linkMaj;
    logic [2:0] linkOdd;
    logic [0:0] wdMaj;
    logic [2:0] wdOdd;
    logic [2:0] pinStable;
    logic latchNow;

    ////////////////////////////////////////////////////////////////
    // Memory path voter, 32 bits wide
    tmrv_vote #(.W(TMRV_MEM_W)) u_memVote (
        .laneA(memRdA),
        .laneB(memRdB),
        .laneC(memRdC),
        .voted(memMaj),
        .laneOdd(memOdd)
    );
    // Separate link voter, so link faults never share the memory path
    tmrv_vote #(.W(TMRV_LINK_W)) u_linkVote (
        .laneA(linkRxA),
        .laneB(linkRxB),
        .laneC(linkRxC),
        .voted(linkMaj),
        .laneOdd(linkOdd)
    );
    // Watchdog voter on synchronised lanes
    tmrv_vote #(.W(1)) u_wdVote (
        .laneA(st_reg.wdS3[0:0]),
        .laneB(st_reg.wdS3[1:1]),
        .laneC(st_reg.wdS3[2:2]),
        .voted(wdMaj),
        .laneOdd(wdOdd)
    );

    // Pin accepted once stages two and three agree
    assign pinStable = ~(st_reg.pinS2 ^ st_reg.pinS3);
    assign latchNow = (pinStable[0] & st_reg.pinS3[0]) | (pinStable[1] & st_reg.pinS3[1]);

    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        // Pin synchronisers; first stage feeds only the second
        st_next.wdS1 = {wdogC, wdogB, wdogA};
        st_next.wdS2 = st_reg.wdS1;
        st_next.wdS3 = st_reg.wdS2;
        st_next.pinS1 = {ejectorOpen, latchBot, latchTop};
        st_next.pinS2 = st_reg.pinS1;
        st_next.pinS3 = st_reg.pinS2;
        // Memory reads voted every cycle they are valid
        st_next.memV = memRdValid;
        if (memRdValid) begin
            st_next.mem = memMaj;
        end
        // Faulty link words are flagged and held off the voted link output
        st_next.linkF = linkRxValid & (linkRxErr | ioModFault);
        st_next.linkV = linkRxValid & ~(linkRxErr | ioModFault);
        if (linkRxValid & ~(linkRxErr | ioModFault)) begin
            st_next.link = linkMaj;
        end
        // Sticky lane flags; only reset clears them
        st_next.mis = st_reg.mis
            | (memRdValid ? memOdd : 3'h0)
            | (linkRxValid ? linkOdd : 3'h0);
        st_next.err = st_reg.err | (|st_next.mis);
        st_next.fpWd = wdMaj[0];
        // Interrupt pulse to each lane on switch actuation edge
        st_next.latchSeen = latchNow;
        st_next.irq = (latchNow & ~st_reg.latchSeen) ? 3'h7 : 3'h0;
        st_next.chg = 1'b0;
        case (st_reg.role)
            TMRV_ACTIVE: begin
                if (pinStable[2] & st_reg.pinS3[2]) begin
                    st_next.role = TMRV_CHANGE;
                    st_next.chg = 1'b1;
                end
            end
            TMRV_STANDBY: begin
                if (peerTrigger) begin
                    st_next.role = TMRV_ACTIVE;
                end
            end
            TMRV_CHANGE: begin
                // Handed over; wait as standby until the peer triggers back
                st_next.role = TMRV_STANDBY;
            end
            default: begin
                st_next.role = TMRV_STANDBY;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.mis <= TMRV_MISMATCH_RST;
            st_reg.err <= TMRV_FLAG_RST;
            st_reg.role <= TMRV_STANDBY;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign memVoted = st_reg.mem;
    assign memVotedValid = st_reg.memV;
    assign linkVoted = st_reg.link;
    assign linkVotedValid = st_reg.linkV;
    assign linkFault = st_reg.linkF;
    assign fpWatchdog = st_reg.fpWd;
    assign errorInd = st_reg.err;
    assign laneMismatch = st_reg.mis;
    assign laneIrq = st_reg.irq;
    assign changeoverReq = st_reg.chg;
    // Gated by the pair status line, so a lone unit never claims the pair
    assign goActive = (st_reg.role == TMRV_ACTIVE) & isActive;

    ////////////////////////////////////////////////////////////////
    a_mem_vote_out: assert property (@(posedge clock) disable iff (!rst_n)
        memRdValid && memRdA == memRdB |=> memVoted == $past(memRdA) && memVotedValid)
        else $error("memory vote wrong");
    a_link_majority: assert property (@(posedge clock) disable iff (!rst_n)
        linkRxValid && !linkRxErr && !ioModFault && linkRxB == linkRxC
        |=> linkVoted == $past(linkRxB)) else $error("link vote wrong");
    a_link_fault_block: assert property (@(posedge clock) disable iff (!rst_n)
        linkRxValid && (linkRxErr || ioModFault) |=> linkFault && !linkVotedValid
        && $stable(linkVoted)) else $error("faulty link data passed");
    a_err_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        errorInd |=> errorInd) else $error("error indication dropped");
    a_mis_sets_err: assert property (@(posedge clock) disable iff (!rst_n)
        memRdValid && memRdA != memRdB && memRdB == memRdC |=> laneMismatch[0] ##1 errorInd)
        else $error("lane A mismatch missed");
    a_wdog_follow: assert property (@(posedge clock) disable iff (!rst_n)
        wdogA && wdogB ##1 wdogA && wdogB ##1 wdogA && wdogB ##1 1 |-> ##1 fpWatchdog)
        else $error("watchdog vote wrong");
    a_irq_all_lanes: assert property (@(posedge clock) disable iff (!rst_n)
        laneIrq != 3'h0 |-> laneIrq == 3'h7 ##1 laneIrq == 3'h0)
        else $error("interrupt not to all lanes");
    a_change_leaves: assert property (@(posedge clock) disable iff (!rst_n)
        changeoverReq |-> !goActive ##1 !changeoverReq) else $error("changeover wrong");

    c_mem_mismatch: cover property (@(posedge clock) disable iff (!rst_n) $rose(errorInd));
    c_link_fault: cover property (@(posedge clock) disable iff (!rst_n) linkFault);
    c_latch_irq: cover property (@(posedge clock) disable iff (!rst_n) laneIrq == 3'h7);
    c_changeover: cover property (@(posedge clock) disable iff (!rst_n) changeoverReq);
endmodule

// ### tb/tmrv_lane_model.sv
// Partner model: three lockstep lanes feeding the memory and link voters
`timescale 1ns/1ns
module tmrv_lane_model
    import tmrv_pkg::*;
(
    // Clock
    clock,
    // Requests from the bench
    memReq,
    linkReq,
    word,
    badLane,
    flip,
    // Lane outputs
    memRdA,
    memRdB,
    memRdC,
    memRdValid,
    linkRxA,
    linkRxB,
    linkRxC,
    linkRxValid
);
    input wire logic clock;
    input wire logic memReq;
    input wire logic linkReq;
    input wire logic [31:0] word;
    input wire logic [1:0] badLane;
    input wire logic [31:0] flip;
    output logic [TMRV_MEM_W-1:0] memRdA = 32'h0;
    output logic [TMRV_MEM_W-1:0] memRdB = 32'h0;
    output logic [TMRV_MEM_W-1:0] memRdC = 32'h0;
    output logic memRdValid = 1'h0;
    output logic [TMRV_LINK_W-1:0] linkRxA = 4'h0;
    output logic [TMRV_LINK_W-1:0] linkRxB = 4'h0;
    output logic [TMRV_LINK_W-1:0] linkRxC = 4'h0;
    output logic linkRxValid = 1'h0;
    ////////////////////////////////////////////////////////////////////////
    // Idle lanes toggle, so stale data never passes for a fresh word
    always_ff @(posedge clock) begin
        memRdValid <= memReq;
        linkRxValid <= linkReq;
        memRdA <= memReq ? word ^ (badLane == 2'h0 ? flip : 32'h0) : ~memRdA;
        memRdB <= memReq ? word ^ (badLane == 2'h1 ? flip : 32'h0) : ~memRdB;
        memRdC <= memReq ? word ^ (badLane == 2'h2 ? flip : 32'h0) : ~memRdC;
        linkRxA <= linkReq ? word[3:0] ^ (badLane == 2'h0 ? flip[3:0] : 4'h0) : ~linkRxA;
        linkRxB <= linkReq ? word[3:0] ^ (badLane == 2'h1 ? flip[3:0] : 4'h0) : ~linkRxB;
        linkRxC <= linkReq ? word[3:0] ^ (badLane == 2'h2 ? flip[3:0] : 4'h0) : ~linkRxC;
    end
endmodule

// ### tb/tmrv_voter_top_bench.sv
// Self-checking bench for the lane voter
`timescale 1ns/1ns
module tmrv_voter_top_bench;
    import tmrv_pkg::*;
    logic clock = 1'h0, rst_n = 1'h0, memReq = 1'h0, linkReq = 1'h0;
    logic linkRxErr = 1'h0, ioModFault = 1'h0, wdogA = 1'h0, wdogB = 1'h0, wdogC = 1'h0;
    logic latchTop = 1'h0, latchBot = 1'h0, ejectorOpen = 1'h0;
    logic isActive = 1'h0, peerTrigger = 1'h0;
    logic [31:0] word = 32'h0, flip = 32'h0;
    logic [1:0] badLane = 2'h3;
    logic [TMRV_MEM_W-1:0] memRdA, memRdB, memRdC, memVoted;
    logic [TMRV_LINK_W-1:0] linkRxA, linkRxB, linkRxC, linkVoted;
    logic memRdValid, linkRxValid, memVotedValid, linkVotedValid, linkFault;
    logic fpWatchdog, errorInd, changeoverReq, goActive;
    logic [2:0] laneMismatch, laneIrq, mm = 3'h0;
    logic [3:0] lastLink = 4'h0;
    logic [15:0] seed = 16'h361e;
    int errors = 0, n_tests = 0;
    tmrv_lane_model i_tmrv_lane_model (.clock, .memReq, .linkReq, .word, .badLane,
        .flip, .memRdA, .memRdB, .memRdC, .memRdValid, .linkRxA, .linkRxB, .linkRxC,
        .linkRxValid);
    tmrv_voter_top i_tmrv_voter_top (.clock, .rst_n, .memRdA, .memRdB, .memRdC,
        .memRdValid, .linkRxA, .linkRxB, .linkRxC, .linkRxValid, .linkRxErr, .ioModFault,
        .wdogA, .wdogB, .wdogC, .latchTop, .latchBot, .ejectorOpen, .isActive, .peerTrigger,
        .memVoted, .memVotedValid, .linkVoted, .linkVotedValid, .linkFault, .fpWatchdog,
        .errorInd, .laneMismatch, .laneIrq, .changeoverReq, .goActive);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clock = ~clock;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Bounded wait: 0 for the interrupt pulse, 1 for the changeover pulse
    task automatic wait_ev(input bit which);
        int i;
        #1;
        for (i = 0; i < 12 && (which ? changeoverReq : |laneIrq) !== 1'b1; i++) tick(1);
        if (i == 12) begin
            errors++;
            report_and_stop();
        end
    endtask
    // One read and one link word, with a lane fault and a link error mixed in
    task automatic vote_op(input logic [1:0] bad, input logic [1:0] err);
        logic [31:0] w;
        w = {seed, lfsr(seed)};
        seed = lfsr(lfsr(seed));
        @(posedge clock);
        {memReq, linkReq, word, flip, badLane} <= {2'h3, w, {16'h0, seed} | 32'h1, bad};
        @(posedge clock);
        {memReq, linkReq, linkRxErr, ioModFault} <= {2'h0, err};
        tick(1);
        if (bad != 2'h3) mm[bad] = 1'b1;
        if (err == 2'h0) lastLink = w[3:0];
        chk(memVoted, w);
        chk(32'(memVotedValid), 32'h1);
        chk(32'(linkVoted), 32'(lastLink));
        chk(32'({linkVotedValid, linkFault}), err == 2'h0 ? 32'h2 : 32'h1);
        chk(32'(laneMismatch), 32'(mm));
        tick(1);
        chk(32'(errorInd), 32'(mm != 3'h0));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        tick(1);
        chk(32'(goActive), 32'h0);
        vote_op(2'h3, 2'h0);
        for (int k = 0; k < 40; k++) begin
            vote_op(seed[1:0], seed[5:4] & seed[3:2]);
        end
        @(posedge clock);
        {wdogA, wdogB, ejectorOpen} <= 3'h7;
        tick(8);
        chk(32'({fpWatchdog, goActive, changeoverReq}), 32'h4);
        @(posedge clock);
        {wdogB, ejectorOpen} <= 2'h0;
        tick(6);
        chk(32'(fpWatchdog), 32'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            {latchTop, latchBot} <= k[0] ? 2'h1 : 2'h2;
            wait_ev(1'b0);
            chk(32'(laneIrq), 32'h7);
            tick(1);
            chk(32'(laneIrq), 32'h0);
            @(posedge clock);
            {latchTop, latchBot} <= 2'h0;
            tick(6);
        end
        @(posedge clock);
        {peerTrigger, isActive} <= 2'h3;
        @(posedge clock);
        peerTrigger <= 1'b0;
        tick(1);
        chk(32'(goActive), 32'h1);
        @(posedge clock);
        ejectorOpen <= 1'b1;
        wait_ev(1'b1);
        tick(3);
        chk(32'({goActive, changeoverReq}), 32'h0);
        @(posedge clock);
        rst_n <= 1'b0;
        tick(2);
        chk(32'({errorInd, laneMismatch}), 32'h0);
        report_and_stop();
    end
endmodule
